// file: src/ast_axil_slave.sv
// AXI4-Lite slave front end turning bus traffic into register strobes
module ast_axil_slave (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire ast_pkg::ast_axil_req_t axiReq,
  output ast_pkg::ast_axil_rsp_t      axiRsp,
  output logic                        wrEn,
  output logic [`AST_ADDR_W-1:0]      wrAddr,
  output logic [31:0]                 wrData,
  output logic [3:0]                  wrStrb,
  input  wire logic                   wrOk,
  output logic                        rdEn,
  output logic [`AST_ADDR_W-1:0]      rdAddr,
  input  wire logic [31:0]            rdData,
  input  wire logic                   rdOk
);
  import ast_pkg::*;
  logic                   awHeld_r;
  logic                   wHeld_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [1:0]             rresp_r;
  logic [31:0]            rdata_r;
  logic [`AST_ADDR_W-1:0] awAddr_r;
  logic [31:0]            wData_r;
  logic [3:0]             wStrb_r;
  logic                   awTake;
  logic                   wTake;

  assign awTake = axiReq.awvalid && !awHeld_r && !bvalid_r;
  assign wTake  = axiReq.wvalid && !wHeld_r && !bvalid_r;
  assign wrEn   = awHeld_r && wHeld_r && !bvalid_r;
  assign wrAddr = awAddr_r;
  assign wrData = wData_r;
  assign wrStrb = wStrb_r;
  assign rdEn   = axiReq.arvalid && !rvalid_r;
  assign rdAddr = axiReq.araddr;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else begin
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= axiReq.awaddr;
      end else if (wrEn) begin
        awHeld_r <= 1'b0;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= axiReq.wdata;
        wStrb_r <= axiReq.wstrb;
      end else if (wrEn) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AST_RESP_OKAY;
    end else if (wrEn) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wrOk ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
    end else if (bvalid_r && axiReq.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `AST_RESP_OKAY;
      rdata_r  <= '0;
    end else if (rdEn) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rdOk ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      rdata_r  <= rdOk ? rdData : 32'h0000_0000;
    end else if (rvalid_r && axiReq.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_comb begin
    axiRsp         = '0;
    axiRsp.awready = !awHeld_r && !bvalid_r;
    axiRsp.wready  = !wHeld_r && !bvalid_r;
    axiRsp.bvalid  = bvalid_r;
    axiRsp.bresp   = bresp_r;
    axiRsp.arready = !rvalid_r;
    axiRsp.rvalid  = rvalid_r;
    axiRsp.rresp   = rresp_r;
    axiRsp.rdata   = rdata_r;
  end
endmodule

// file: src/ast_params.svh
// Constants for the asynchronous serial transmitter
// Notes on behaviour
// - Word length is 8 or 9 bits
// - Start bit drives the line low
// - Stop bit drives the line high
// - Idle character is 10 or 11 highs
// - Break is low bits then one high
// - Ninth data bit comes from control bit
// - Data bits leave least significant first
// - Enabling sends a preamble of ones first
// - Empty flag sets when hold buffer empties
// - Empty flag with enable raises interrupt
// - Write during sending waits in hold buffer
// - Write while idle loads shifter, starts, sets
// - Done flag after last stop, optional interrupt
// - Done flag cleared by same ordered pair
// - Setting break loads a break character
// - Breaks repeat, then one high bit
// - Enable toggle queues preamble after word
// - Preamble counted apart from stop bit
// - Enable toggle discards the held word
// - One bit time delay after enabling when idle
// - Line rests high; released once disabled and the word under way ends
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
`define AST_ADDR_W        4
`define AST_OFF_CTRL      4'h0
`define AST_OFF_STATUS    4'h4
`define AST_OFF_DATA      4'h8
`define AST_CTRL_RESET    6'h00
`define AST_TX_BUFFER_EMPTY_FLAG_RESET    1'b1
`define AST_TC_RESET      1'b1
`define AST_LEN8          4'hA
`define AST_LEN9          4'hB
`define AST_RESP_OKAY     2'h0
`define AST_RESP_SLVERR   2'h2
`endif

// file: src/ast_pkg.sv
// Types shared by the serial transmitter and its bus slave
`include "ast_params.svh"
package ast_pkg;
  typedef struct packed {
    logic txDoneIrqEn;
    logic txEmptyIrqEn;
    logic breakSendCtl;
    logic txOnCtl;
    logic ninthTxBit;
    logic wordLen9;
  } ast_ctrl_t;

  typedef struct packed {
    logic [`AST_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   bready;
    logic [`AST_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   rready;
  } ast_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ast_axil_rsp_t;

  typedef enum logic [1:0] {JOB_NONE, JOB_PRE, JOB_BRK, JOB_TAIL} ast_job_t;
endpackage

// file: src/ast_tx.sv
// Asynchronous serial transmitter with AXI4-Lite register access
module ast_tx (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire ast_pkg::ast_axil_req_t axiReq,
  output ast_pkg::ast_axil_rsp_t      axiRsp,
  input  wire logic                   baudTick,
  input  wire logic [1:0]             cpuIrqMask,
  output logic                        irq,
  output logic                        txdOut,
  output logic                        txdOe_n
);
  import ast_pkg::*;

  logic                   wrEn;
  logic [`AST_ADDR_W-1:0] wrAddr;
  logic [31:0]            wrData;
  logic [3:0]             wrStrb;
  logic                   wrOk;
  logic                   rdEn;
  logic [`AST_ADDR_W-1:0] rdAddr;
  logic [31:0]            rdData;
  logic                   rdOk;

  ast_ctrl_t              ctrl_r;
  logic                   tx_buffer_empty_flag_r;
  logic                   tc_r;
  logic                   arm_r;
  logic [7:0]             hold_r;
  logic                   holdFull_r;
  logic [10:0]            shift_r;
  logic [3:0]             cnt_r;
  logic                   active_r;
  logic                   lastData_r;
  logic                   line_r;
  logic                   preReq_r;
  logic                   delay_r;
  logic                   brkTail_r;

  logic                   ctrlWr;
  logic                   dataWr;
  logic                   statRd;
  logic [3:0]             frameLen;
  logic                   engineIdle;
  logic                   boundary;
  ast_job_t               job;
  logic                   pickData;
  logic                   directLoad;
  logic                   teFall;
  logic                   teRise;
  logic [10:0]            holdFrame;
  logic [10:0]            wrFrame;

  ast_axil_slave u_slave (
    .clock  (clock),
    .rst_n  (rst_n),
    .axiReq (axiReq),
    .axiRsp (axiRsp),
    .wrEn   (wrEn),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .wrStrb (wrStrb),
    .wrOk   (wrOk),
    .rdEn   (rdEn),
    .rdAddr (rdAddr),
    .rdData (rdData),
    .rdOk   (rdOk)
  );

  assign wrOk   = (wrAddr == `AST_OFF_CTRL) || (wrAddr == `AST_OFF_STATUS)
               || (wrAddr == `AST_OFF_DATA);
  assign rdOk   = wrOk_rd(rdAddr);
  assign ctrlWr = wrEn && wrStrb[0] && (wrAddr == `AST_OFF_CTRL);
  assign dataWr = wrEn && wrStrb[0] && (wrAddr == `AST_OFF_DATA);
  assign statRd = rdEn && (rdAddr == `AST_OFF_STATUS);

  function automatic logic wrOk_rd(input logic [`AST_ADDR_W-1:0] a);
    wrOk_rd = (a == `AST_OFF_CTRL) || (a == `AST_OFF_STATUS) || (a == `AST_OFF_DATA);
  endfunction

  // Data register reads back the held word; status has only two live bits
  always_comb begin
    rdData = 32'h0000_0000;
    case (rdAddr)
      `AST_OFF_CTRL:   rdData = {26'h0, ctrl_r};
      `AST_OFF_STATUS: rdData = {30'h0, tc_r, tx_buffer_empty_flag_r};
      `AST_OFF_DATA:   rdData = {24'h0, hold_r};
      default:         rdData = 32'h0000_0000;
    endcase
  end

  assign frameLen  = ctrl_r.wordLen9 ? `AST_LEN9 : `AST_LEN8;
  // Stop bit above the data; 8-bit frames carry a spare high bit on top
  assign holdFrame = ctrl_r.wordLen9 ? {1'b1, ctrl_r.ninthTxBit, hold_r, 1'b0}
                                     : {2'b11, hold_r, 1'b0};
  assign wrFrame   = ctrl_r.wordLen9 ? {1'b1, ctrl_r.ninthTxBit, wrData[7:0], 1'b0}
                                     : {2'b11, wrData[7:0], 1'b0};
  assign teFall    = ctrlWr && ctrl_r.txOnCtl && !wrData[2];
  assign teRise    = ctrlWr && !ctrl_r.txOnCtl && wrData[2];
  assign engineIdle = !active_r && (cnt_r == 4'h0) && !delay_r;
  assign boundary  = baudTick && (cnt_r == 4'h0) && !delay_r;

  // Job choice at a bit boundary: preamble, break, break tail, then data
  always_comb begin
    job      = JOB_NONE;
    pickData = 1'b0;
    if (ctrl_r.txOnCtl) begin
      if (preReq_r) begin
        job = JOB_PRE;
      end else if (ctrl_r.breakSendCtl) begin
        job = JOB_BRK;
      end else if (brkTail_r) begin
        job = JOB_TAIL;
      end else if (holdFull_r) begin
        pickData = 1'b1;
      end
    end
  end

  assign directLoad = dataWr && engineIdle && ctrl_r.txOnCtl && !preReq_r
                   && !ctrl_r.breakSendCtl && !brkTail_r && !holdFull_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= `AST_CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl_r <= wrData[5:0];
    end
  end

  // Ordered clear: a status read arms, the next data write clears
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arm_r <= 1'b0;
    end else if (statRd) begin
      arm_r <= 1'b1;
    end else if (dataWr) begin
      arm_r <= 1'b0;
    end
  end

  // Set wins over the software clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_buffer_empty_flag_r <= `AST_TX_BUFFER_EMPTY_FLAG_RESET;
    end else if (directLoad || (boundary && pickData) || teFall) begin
      tx_buffer_empty_flag_r <= 1'b1;
    end else if (dataWr && arm_r) begin
      tx_buffer_empty_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tc_r <= `AST_TC_RESET;
    end else if (boundary && active_r && lastData_r && !pickData && job == JOB_NONE) begin
      tc_r <= 1'b1;
    end else if (dataWr && arm_r) begin
      tc_r <= 1'b0;
    end
  end

  // Hold buffer; a toggle of the enable throws its word away
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_r     <= 8'h00;
      holdFull_r <= 1'b0;
    end else if (teFall) begin
      holdFull_r <= 1'b0;
    end else if (dataWr && !directLoad) begin
      hold_r     <= wrData[7:0];
      holdFull_r <= 1'b1;
    end else if (boundary && pickData) begin
      holdFull_r <= 1'b0;
    end
  end

  // Enable requests: preamble always, plus one idle bit when quiet
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      preReq_r <= 1'b0;
      delay_r  <= 1'b0;
    end else begin
      if (teRise) begin
        preReq_r <= 1'b1;
      end else if (boundary && job == JOB_PRE) begin
        preReq_r <= 1'b0;
      end else if (!ctrl_r.txOnCtl && engineIdle) begin
        preReq_r <= 1'b0;
      end
      if (teRise && engineIdle) begin
        delay_r <= 1'b1;
      end else if (baudTick) begin
        delay_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      brkTail_r <= 1'b0;
    end else if (boundary && job == JOB_BRK) begin
      brkTail_r <= 1'b1;
    end else if (boundary && job == JOB_TAIL) begin
      brkTail_r <= 1'b0;
    end
  end

  // Bit engine: one bit leaves per baud tick, shifter drains LSB first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r    <= 11'h7FF;
      cnt_r      <= 4'h0;
      active_r   <= 1'b0;
      lastData_r <= 1'b0;
      line_r     <= 1'b1;
    end else begin
      if (baudTick && delay_r) begin
        line_r <= 1'b1;
      end else if (baudTick && cnt_r != 4'h0) begin
        line_r  <= shift_r[0];
        shift_r <= {1'b1, shift_r[10:1]};
        cnt_r   <= cnt_r - 4'h1;
      end else if (boundary) begin
        active_r <= (job != JOB_NONE) || pickData;
        case (job)
          JOB_PRE: begin
            line_r     <= 1'b1;
            shift_r    <= 11'h7FF;
            cnt_r      <= frameLen - 4'h1;
            lastData_r <= 1'b0;
          end
          JOB_BRK: begin
            line_r     <= 1'b0;
            shift_r    <= 11'h000;
            cnt_r      <= frameLen - 4'h1;
            lastData_r <= 1'b0;
          end
          JOB_TAIL: begin
            line_r     <= 1'b1;
            cnt_r      <= 4'h0;
            lastData_r <= 1'b0;
          end
          default: begin
            if (pickData) begin
              line_r     <= holdFrame[0];
              shift_r    <= {1'b1, holdFrame[10:1]};
              cnt_r      <= frameLen - 4'h1;
              lastData_r <= 1'b1;
            end else begin
              line_r     <= 1'b1;
              lastData_r <= 1'b0;
            end
          end
        endcase
      end
      if (directLoad) begin
        shift_r    <= wrFrame;
        cnt_r      <= frameLen;
        active_r   <= 1'b1;
        lastData_r <= 1'b1;
      end
    end
  end

  // Pin is driven while enabled or until the word under way ends
  assign txdOut  = line_r;
  assign txdOe_n = !(ctrl_r.txOnCtl || active_r || cnt_r != 4'h0);
  assign irq     = (cpuIrqMask == 2'h0)
                && ((tx_buffer_empty_flag_r && ctrl_r.txEmptyIrqEn) || (tc_r && ctrl_r.txDoneIrqEn));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_start_low: assert property (boundary && job == JOB_NONE && pickData |=> !txdOut)
    else $error("start bit not low");
  chk_stop_high: assert property (baudTick && !delay_r && cnt_r == 4'h1 && lastData_r
    |=> txdOut)
    else $error("stop bit not high");
  chk_break_low: assert property (boundary && job == JOB_BRK |=> !txdOut && brkTail_r)
    else $error("break bit not low");
  chk_tail_high: assert property (boundary && job == JOB_TAIL |=> txdOut && !brkTail_r)
    else $error("break tail not high");
  chk_pre_len: assert property (boundary && job == JOB_PRE
    |=> txdOut && cnt_r == ($past(frameLen) - 4'h1))
    else $error("preamble length wrong");
  chk_direct_load: assert property (directLoad |=> tx_buffer_empty_flag_r && cnt_r == $past(frameLen))
    else $error("direct load failed");
  chk_hold_write: assert property (dataWr && !directLoad && !teFall
    |=> holdFull_r && hold_r == $past(wrData[7:0]))
    else $error("write not held");
  chk_pair_clear: assert property (dataWr && arm_r && cnt_r > 4'h1 |=> !tc_r)
    else $error("done flag not cleared");
  chk_toggle_drop: assert property (teFall |=> !holdFull_r && tx_buffer_empty_flag_r)
    else $error("held word kept after toggle");
  chk_enable_delay: assert property (teRise && engineIdle |=> delay_r && preReq_r)
    else $error("no delay after enable");
  chk_irq_empty: assert property (tx_buffer_empty_flag_r && ctrl_r.txEmptyIrqEn && cpuIrqMask == 2'h0
    |-> irq)
    else $error("empty interrupt missing");
  chk_pin_release: assert property (!ctrl_r.txOnCtl && !active_r && cnt_r == 4'h0
    |-> txdOe_n)
    else $error("pin not released");
  chk_shift_lsb: assert property (baudTick && !delay_r && cnt_r != 4'h0
    |=> txdOut == $past(shift_r[0]))
    else $error("bit order wrong");

  cov_data_frame: cover property (boundary && pickData);
  cov_break_char: cover property (boundary && job == JOB_BRK);
  cov_preamble:   cover property (boundary && job == JOB_PRE);
  cov_done_set:   cover property ($rose(tc_r));
endmodule

// file: tb/ast_rx_model.sv
// Remote serial receiver model that decodes frames seen on the line
module ast_rx_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        baudTick,
  input  wire logic        txdOut,
  input  wire logic        txdOe_n,
  input  wire logic        wordLen9,
  output logic [8:0]       rxWord,
  output logic [15:0]      rxCount,
  output logic [15:0]      brkCount,
  output logic [15:0]      idleBefore
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        line;
  logic        inFrame;
  logic [3:0]  bitIdx;
  logic [8:0]  shiftR;
  logic [15:0] highRun;
  // Pull-up holds a released pin high
  assign line = txdOe_n ? 1'b1 : txdOut;
  // One sample per bit, taken on the tick that ends it
  always @(posedge clock) begin
    if (!rst_n) begin
      inFrame <= 1'b0;
      bitIdx <= 4'h0;
      shiftR <= 9'h000;
      highRun <= 16'h0000;
      rxWord <= 9'h000;
      rxCount <= 16'h0000;
      brkCount <= 16'h0000;
      idleBefore <= 16'h0000;
    end else if (baudTick) begin
      if (!inFrame) begin
        if (txdOe_n) begin
          highRun <= 16'h0000;
        end else if (line) begin
          highRun <= highRun + 16'h0001;
        end else begin
          inFrame <= 1'b1;
          bitIdx <= 4'h0;
          shiftR <= 9'h000;
          idleBefore <= highRun;
          highRun <= 16'h0000;
        end
      end else if (bitIdx < (wordLen9 ? 4'h9 : 4'h8)) begin
        shiftR[bitIdx] <= line;
        bitIdx <= bitIdx + 4'h1;
      end else begin
        inFrame <= 1'b0;
        rxWord <= shiftR;
        // A low stop bit marks a break
        if (line) rxCount <= rxCount + 16'h0001;
        else brkCount <= brkCount + 16'h0001;
      end
    end
  end
endmodule

// file: tb/tb_async_serial_transmitter.sv
// Self-checking bench for the serial transmitter and its register port
`include "ast_params.svh"
module tb_async_serial_transmitter;
  timeunit 1ns;
  timeprecision 1ps;
  import ast_pkg::*;
  logic          clock;
  logic          rst_n;
  ast_axil_req_t req;
  ast_axil_rsp_t rsp;
  logic          baudTick;
  logic [2:0]    tickDiv;
  logic [1:0]    cpuIrqMask;
  logic          irq;
  logic          txdOut;
  logic          txdOe_n;
  logic          wordLen9;
  logic [8:0]    rxWord;
  logic [15:0]   rxCount;
  logic [15:0]   brkCount;
  logic [15:0]   idleBefore;
  logic [31:0]   rngState;
  logic [31:0]   rdVal;
  logic [1:0]    resp;
  int            errors = 0;
  int            cmpCount = 0;

  ast_tx u_ast_tx (.clock(clock), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp),
    .baudTick(baudTick), .cpuIrqMask(cpuIrqMask), .irq(irq), .txdOut(txdOut),
    .txdOe_n(txdOe_n));
  ast_rx_model u_ast_rx_model (.clock(clock), .rst_n(rst_n), .baudTick(baudTick),
    .txdOut(txdOut), .txdOe_n(txdOe_n), .wordLen9(wordLen9), .rxWord(rxWord),
    .rxCount(rxCount), .brkCount(brkCount), .idleBefore(idleBefore));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Eight-cycle bit time keeps frames short
  always @(posedge clock) begin
    tickDiv <= tickDiv + 3'h1;
    baudTick <= (tickDiv == 3'h7);
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [8:0] frameWord(input logic [7:0] d, input logic len9,
                                           input logic nb);
    return {len9 & nb, d};
  endfunction

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      finish_test();
    end
  endtask

  // Handshake seen in the low phase, which is what stands at the next rising edge
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    int   n = 0;
    logic awRdy;
    logic wRdy;
    logic bVld;
    @(posedge clock);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge clock);
      awRdy = rsp.awready;
      wRdy = rsp.wready;
      bVld = rsp.bvalid;
      if (bVld) resp = rsp.bresp;
      @(posedge clock);
      n++;
      if (awRdy && req.awvalid) req.awvalid <= 1'b0;
      if (wRdy && req.wvalid) req.wvalid <= 1'b0;
    end while (!bVld && n < 100);
    req.bready <= 1'b0;
    bound(n, 100);
  endtask

  task automatic axiRead(input logic [3:0] a);
    int   n = 0;
    logic arRdy;
    logic rVld;
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge clock);
      arRdy = rsp.arready;
      rVld = rsp.rvalid;
      if (rVld) rdVal = rsp.rdata;
      if (rVld) resp = rsp.rresp;
      @(posedge clock);
      n++;
      if (arRdy && req.arvalid) req.arvalid <= 1'b0;
    end while (!rVld && n < 100);
    req.rready <= 1'b0;
    bound(n, 100);
  endtask

  // Status access first, so the data write clears the flags
  task automatic sendWord(input logic [7:0] d);
    axiRead(`AST_OFF_STATUS);
    axiWrite(`AST_OFF_DATA, {24'h0, d});
  endtask

  task automatic waitCnt(input logic brk, input int target);
    int n = 0;
    while ((brk ? brkCount : rxCount) < target && n < 4000) begin
      @(posedge clock);
      n++;
    end
    bound(n, 4000);
  endtask

  initial begin
    logic [7:0]  dA;
    logic [7:0]  dB;
    logic [7:0]  dC;
    logic        len;
    logic        nb;
    logic [31:0] ctl;
    int          base;
    rst_n = 1'b0;
    req = '0;
    baudTick = 1'b0;
    tickDiv = 3'h0;
    cpuIrqMask = 2'b00;
    wordLen9 = 1'b0;
    rngState = 32'h000009BB;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    axiRead(`AST_OFF_STATUS);
    check("status rst", rdVal, 32'h00000003);
    axiRead(`AST_OFF_CTRL);
    check("ctrl rst", rdVal, 32'h00000000);
    check("pin released", {31'h0, txdOe_n}, 32'h00000001);
    axiRead(4'hC);
    check("bad rd resp", {30'h0, resp}, {30'h0, `AST_RESP_SLVERR});
    axiWrite(4'hC, 32'h0000005A);
    check("bad wr resp", {30'h0, resp}, {30'h0, `AST_RESP_SLVERR});
    // Enable, then toggle while busy, over every length and ninth-bit value
    for (int i = 0; i < 4; i++) begin
      rngState = xorshift(rngState);
      len = i[0];
      nb = i[1];
      dA = rngState[7:0];
      dB = rngState[15:8];
      dC = rngState[23:16];
      ctl = {29'h0, 1'b1, nb, len};
      wordLen9 <= len;
      axiWrite(`AST_OFF_CTRL, {29'h0, 1'b0, nb, len});
      check("pin off", {31'h0, txdOe_n}, 32'h1);
      axiWrite(`AST_OFF_CTRL, ctl);
      base = rxCount;
      sendWord(dA);
      waitCnt(1'b0, base + 1);
      check("word A", rxWord, frameWord(dA, len, nb));
      check("enable idle", idleBefore >= 11 + len, 1);
      sendWord(dB);
      sendWord(dA);
      axiWrite(`AST_OFF_CTRL, {29'h0, 1'b0, nb, len});
      axiWrite(`AST_OFF_CTRL, ctl);
      sendWord(dC);
      waitCnt(1'b0, base + 2);
      check("word B", rxWord, frameWord(dB, len, nb));
      waitCnt(1'b0, base + 3);
      check("word C", rxWord, frameWord(dC, len, nb));
      check("preamble", idleBefore, 10 + len);
    end
    // Direct load, held word and the flag sequence
    wordLen9 <= 1'b0;
    axiWrite(`AST_OFF_CTRL, 32'h00000004);
    base = rxCount;
    sendWord(8'h00);
    axiRead(`AST_OFF_STATUS);
    check("empty direct", rdVal, 32'h1);
    sendWord(8'hFF);
    axiRead(`AST_OFF_STATUS);
    check("empty held", rdVal, 32'h0);
    waitCnt(1'b0, base + 1);
    axiRead(`AST_OFF_STATUS);
    check("empty moved", rdVal, 32'h1);
    waitCnt(1'b0, base + 2);
    check("no gap", idleBefore, 0);
    check("word FF", rxWord, 32'h0FF);
    axiRead(`AST_OFF_STATUS);
    check("done set", rdVal, 32'h3);
    axiWrite(`AST_OFF_DATA, 32'h0000003C);
    waitCnt(1'b0, base + 3);
    axiWrite(`AST_OFF_DATA, 32'h000000C3);
    axiRead(`AST_OFF_STATUS);
    check("no arm", rdVal, 32'h3);
    waitCnt(1'b0, base + 4);
    check("word C3", rxWord, 32'h0C3);
    // Interrupt from each flag, gated by the processor mask
    axiWrite(`AST_OFF_CTRL, 32'h00000024);
    check("irq done", irq, 1);
    cpuIrqMask <= 2'b10;
    @(posedge clock);
    check("irq masked", irq, 0);
    cpuIrqMask <= 2'b00;
    sendWord(8'h81);
    check("irq cleared", irq, 0);
    waitCnt(1'b0, base + 5);
    axiRead(`AST_OFF_STATUS);
    check("irq again", irq, 1);
    axiWrite(`AST_OFF_CTRL, 32'h00000014);
    check("irq empty", irq, 1);
    cpuIrqMask <= 2'b01;
    @(posedge clock);
    check("irq empty off", irq, 0);
    cpuIrqMask <= 2'b00;
    // Breaks repeat while set, then a high bit precedes the next start
    base = brkCount;
    axiWrite(`AST_OFF_CTRL, 32'h0000000C);
    waitCnt(1'b1, base + 2);
    check("break bits", rxWord, 0);
    axiWrite(`AST_OFF_CTRL, 32'h00000004);
    base = rxCount;
    sendWord(8'h5A);
    waitCnt(1'b0, base + 1);
    check("after break", rxWord, 32'h05A);
    check("tail high", idleBefore >= 1, 1);
    finish_test();
  end
endmodule
